/* hdl/gpio_pkg.sv */
package gpio_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] OFS_P1_IN = 12'h000;
	localparam logic [11:0] OFS_P1_OUT = 12'h004;
	localparam logic [11:0] OFS_P1_DIR = 12'h008;
	localparam logic [11:0] OFS_P1_FLAG = 12'h00c;
	localparam logic [11:0] OFS_P1_EDGE = 12'h010;
	localparam logic [11:0] OFS_P1_EN = 12'h014;
	localparam logic [11:0] OFS_P1_SEL = 12'h018;
	localparam logic [11:0] OFS_P2_IN = 12'h020;
	localparam logic [11:0] OFS_P2_OUT = 12'h024;
	localparam logic [11:0] OFS_P2_DIR = 12'h028;
	localparam logic [11:0] OFS_P2_FLAG = 12'h02c;
	localparam logic [11:0] OFS_P2_EDGE = 12'h030;
	localparam logic [11:0] OFS_P2_EN = 12'h034;
	localparam logic [11:0] OFS_P2_SEL = 12'h038;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Bonded pins of port 2 (bits 6 and 7 have no pad)
	localparam logic [7:0] P2_BONDED = 8'h3f;
endpackage

/* hdl/dual_port_pin_function_mux.sv */
// Overview of operation
// - P1.0 drives low, feeds timer clock; P1.1-3 compare out 0-2, capture A0-A2
// - P1.4 outputs submain clock, P1.5-7 compare outputs 0-2, no inputs fed
// - P2.0 aux clock, P2.1 low feeding alternate clock, P2.2 comparator, capture B0
// - P2.3 and P2.4 output compare outputs 1 and 2, no inputs fed
// - P2.5 is oscillator resistor pin; peripheral output low, input unused
// - Output enable of every bonded pin comes only from its direction bit
// - Each bit has input, enable, flag, edge, select, direction and output bits
// - P2 bits 6 and 7 unbonded; peripheral output low, registers kept
// - Software may set unbonded flags to request interrupts, gated by enables
// - Unbonded flags change only through software writes
// - Pull resistors are factory fixed; no run-time control exists
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
module dual_port_pin_function_mux (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] p1_pin_in,
	output logic [7:0] p1_pin_out,
	output logic [7:0] p1_pin_oe,
	input wire logic [7:0] p2_pin_in,
	output logic [7:0] p2_pin_out,
	output logic [7:0] p2_pin_oe,
	input wire logic timer_compare_output_0,
	input wire logic timer_compare_output_1,
	input wire logic timer_compare_output_2,
	input wire logic submain_clock,
	input wire logic aux_clock,
	input wire logic comparator_result,
	output logic timer_clock_input,
	output logic timer_alternate_clock_input,
	output logic capture_input_a0,
	output logic capture_input_a1,
	output logic capture_input_a2,
	output logic capture_input_b0,
	output logic p1_irq,
	output logic p2_irq
);
	import gpio_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] p1_out, p1_dir, p1_flag, p1_edge, p1_en, p1_sel;
	logic [7:0] p2_out, p2_dir, p2_flag, p2_edge, p2_en, p2_sel;
	logic [7:0] p1_meta, p1_sync, p1_prev;
	logic [7:0] p2_meta, p2_sync, p2_prev;
	logic [7:0] p1_func, p2_func, p1_evt, p2_evt;
	logic [2:0] hist_fill;
	logic wr;

	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Input synchroniser and edge history; pull choice is not programmable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p1_meta <= RST_BYTE;
			p1_sync <= RST_BYTE;
			p1_prev <= RST_BYTE;
			p2_meta <= RST_BYTE;
			p2_sync <= RST_BYTE;
			p2_prev <= RST_BYTE;
		end else begin
			p1_meta <= p1_pin_in;
			p1_sync <= p1_meta;
			p1_prev <= p1_sync;
			p2_meta <= p2_pin_in & P2_BONDED;
			p2_sync <= p2_meta;
			p2_prev <= p2_sync;
		end
	end

	// Edge history fill; a pin idling high must not look like an edge after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_fill <= 3'h0;
		end else begin
			hist_fill <= {hist_fill[1:0], 1'b1};
		end
	end

	// Per-bit edge detect, only bonded pins can fire
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_edge
			assign p1_evt[i] = hist_fill[2] & (p1_edge[i] ? (p1_prev[i] & ~p1_sync[i])
				: (~p1_prev[i] & p1_sync[i]));
			assign p2_evt[i] = hist_fill[2] & P2_BONDED[i]
				& (p2_edge[i] ? (p2_prev[i] & ~p2_sync[i])
				: (~p2_prev[i] & p2_sync[i]));
		end
	endgenerate

	// Control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p1_out <= RST_BYTE;
			p1_dir <= RST_BYTE;
			p1_edge <= RST_BYTE;
			p1_en <= RST_BYTE;
			p1_sel <= RST_BYTE;
			p2_out <= RST_BYTE;
			p2_dir <= RST_BYTE;
			p2_edge <= RST_BYTE;
			p2_en <= RST_BYTE;
			p2_sel <= RST_BYTE;
		end else if (wr) begin
			unique case (paddr)
				OFS_P1_OUT: p1_out <= pwdata[7:0];
				OFS_P1_DIR: p1_dir <= pwdata[7:0];
				OFS_P1_EDGE: p1_edge <= pwdata[7:0];
				OFS_P1_EN: p1_en <= pwdata[7:0];
				OFS_P1_SEL: p1_sel <= pwdata[7:0];
				OFS_P2_OUT: p2_out <= pwdata[7:0];
				OFS_P2_DIR: p2_dir <= pwdata[7:0];
				OFS_P2_EDGE: p2_edge <= pwdata[7:0];
				OFS_P2_EN: p2_en <= pwdata[7:0];
				OFS_P2_SEL: p2_sel <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Flags: software write sets the written value, pin event wins over it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p1_flag <= RST_BYTE;
			p2_flag <= RST_BYTE;
		end else begin
			if (wr && paddr == OFS_P1_FLAG)
				p1_flag <= pwdata[7:0] | p1_evt;
			else
				p1_flag <= p1_flag | p1_evt;
			if (wr && paddr == OFS_P2_FLAG)
				p2_flag <= pwdata[7:0] | p2_evt;
			else
				p2_flag <= p2_flag | p2_evt;
		end
	end

	// Interrupt requests
	assign p1_irq = |(p1_flag & p1_en);
	assign p2_irq = |(p2_flag & p2_en);

	// Peripheral output per pin
	assign p1_func = {timer_compare_output_2, timer_compare_output_1,
		timer_compare_output_0, submain_clock,
		timer_compare_output_2, timer_compare_output_1,
		timer_compare_output_0, 1'b0};
	assign p2_func = {2'b00, 1'b0,
		timer_compare_output_2, timer_compare_output_1,
		comparator_result, 1'b0, aux_clock};

	// Pin drive and enable
	assign p1_pin_out = (p1_sel & p1_func) | (~p1_sel & p1_out);
	assign p2_pin_out = ((p2_sel & p2_func) | (~p2_sel & p2_out)) & P2_BONDED;
	assign p1_pin_oe = p1_dir;
	assign p2_pin_oe = p2_dir & P2_BONDED;

	// Peripheral inputs, gated by select
	assign timer_clock_input = p1_sel[0] & p1_sync[0];
	assign capture_input_a0 = p1_sel[1] & p1_sync[1];
	assign capture_input_a1 = p1_sel[2] & p1_sync[2];
	assign capture_input_a2 = p1_sel[3] & p1_sync[3];
	assign timer_alternate_clock_input = p2_sel[1] & p2_sync[1];
	assign capture_input_b0 = p2_sel[2] & p2_sync[2];

	// Read data register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFS_P1_IN: prdata <= {24'h000000, p1_sync};
				OFS_P1_OUT: prdata <= {24'h000000, p1_out};
				OFS_P1_DIR: prdata <= {24'h000000, p1_dir};
				OFS_P1_FLAG: prdata <= {24'h000000, p1_flag};
				OFS_P1_EDGE: prdata <= {24'h000000, p1_edge};
				OFS_P1_EN: prdata <= {24'h000000, p1_en};
				OFS_P1_SEL: prdata <= {24'h000000, p1_sel};
				OFS_P2_IN: prdata <= {24'h000000, p2_sync};
				OFS_P2_OUT: prdata <= {24'h000000, p2_out};
				OFS_P2_DIR: prdata <= {24'h000000, p2_dir};
				OFS_P2_FLAG: prdata <= {24'h000000, p2_flag};
				OFS_P2_EDGE: prdata <= {24'h000000, p2_edge};
				OFS_P2_EN: prdata <= {24'h000000, p2_en};
				OFS_P2_SEL: prdata <= {24'h000000, p2_sel};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule // dual_port_pin_function_mux

/* tb/gpio_properties.sv */
`timescale 1ns/100ps
module gpio_properties (
	input wire logic clk, rst_n, psel, penable, pwrite, pready, pslverr,
	input wire logic [31:0] prdata,
	input wire logic [7:0] p1_pin_in, p2_pin_in, p2_pin_out, p2_pin_oe,
	input wire logic timer_clock_input, timer_alternate_clock_input,
	input wire logic capture_input_a0, capture_input_a1, capture_input_a2, capture_input_b0
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
		else $error("slow answer");
	a_read_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("rdata moved");
	a_tclk_sync: assert property (timer_clock_input |-> $past(p1_pin_in[0], 2))
		else $error("tclk");
	a_capture_a: assert property (({capture_input_a2, capture_input_a1, capture_input_a0}
		& ~$past(p1_pin_in[3:1], 2)) == 3'h0) else $error("cap a");
	a_alt_clock: assert property (timer_alternate_clock_input |-> $past(p2_pin_in[1], 2))
		else $error("alt clk");
	a_capture_b: assert property (capture_input_b0 |-> $past(p2_pin_in[2], 2))
		else $error("cap b");
	a_no_drive: assert property (p2_pin_oe[7:6] == 2'h0)
		else $error("unbonded oe");
	a_out_low: assert property (p2_pin_out[7:6] == 2'h0)
		else $error("unbonded out");
endmodule // gpio_properties
bind dual_port_pin_function_mux gpio_properties u_gpio_properties (.*);

/* tb/board_model.sv */
`timescale 1ns/100ps
module board_model (
	input wire logic clk,
	input wire logic [7:0] p1_ext, p2_ext, p1_pin_out, p1_pin_oe, p2_pin_out, p2_pin_oe,
	output wire logic [7:0] p1_pin_in, p2_pin_in,
	output wire logic timer_compare_output_0, timer_compare_output_1, timer_compare_output_2,
	output wire logic submain_clock, aux_clock, comparator_result
);
	logic [5:0] n = 6'h00;
	// Driven pads follow the device, the rest follow the board
	assign p1_pin_in = (p1_pin_oe & p1_pin_out) | (~p1_pin_oe & p1_ext);
	assign p2_pin_in = (p2_pin_oe & p2_pin_out) | (~p2_pin_oe & p2_ext);
	// Timer and clock signals keep moving
	always @(posedge clk) begin
		n <= n + 6'h01;
	end
	assign {timer_compare_output_2, timer_compare_output_1, timer_compare_output_0} = n[5:3];
	assign {submain_clock, aux_clock, comparator_result} = n[2:0];
endmodule // board_model

/* tb/dual_port_pin_function_mux_bench.sv */
`timescale 1ns/100ps
module dual_port_pin_function_mux_bench;
	import gpio_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [7:0] p1_ext = 8'h00, p2_ext = 8'h00;
	logic [11:0] regs [10] = '{OFS_P1_OUT, OFS_P1_DIR, OFS_P1_EDGE, OFS_P1_EN, OFS_P1_SEL,
		OFS_P2_OUT, OFS_P2_DIR, OFS_P2_EDGE, OFS_P2_EN, OFS_P2_SEL};
	wire [31:0] prdata;
	wire [7:0] p1_pin_in, p1_pin_out, p1_pin_oe, p2_pin_in, p2_pin_out, p2_pin_oe;
	wire pready, pslverr, timer_compare_output_0, timer_compare_output_1, timer_compare_output_2;
	wire submain_clock, aux_clock, comparator_result, timer_clock_input, p1_irq, p2_irq;
	wire timer_alternate_clock_input, capture_input_a0, capture_input_a1, capture_input_a2;
	wire capture_input_b0;
	int fails = 0, tests_run = 0;
	dual_port_pin_function_mux u_dual_port_pin_function_mux (.*);
	board_model u_board_model (.*);
	always #20 clk = ~clk;
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; waits for pready in the access phase
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		fails++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		foreach (regs[i]) begin
			xfer(0, regs[i], 0);
			chk("reset", rd, 0);
			xfer(1, regs[i], 32'h5a);
			xfer(0, regs[i], 0);
			chk("readback", rd, 32'h5a);
		end
		xfer(0, 12'h03c, 0);
		chk("unmapped", rd, 0);
		$display("registers done");
		xfer(1, OFS_P1_DIR, 32'hff);
		xfer(1, OFS_P2_DIR, 32'hff);
		xfer(1, OFS_P1_SEL, 32'hff);
		xfer(1, OFS_P2_SEL, 32'hff);
		#1;
		chk("p1 oe", p1_pin_oe, 8'hff);
		chk("p2 oe", p2_pin_oe, 8'h3f);
		chk("p1 out", p1_pin_out, {timer_compare_output_2, timer_compare_output_1,
			timer_compare_output_0, submain_clock, timer_compare_output_2,
			timer_compare_output_1, timer_compare_output_0, 1'b0});
		chk("p2 out", p2_pin_out, {3'h0, timer_compare_output_2, timer_compare_output_1,
			comparator_result, 1'b0, aux_clock});
		xfer(1, OFS_P1_SEL, 0);
		#1 chk("plain out", p1_pin_out, 8'h5a);
		xfer(1, OFS_P1_DIR, 0);
		xfer(1, OFS_P2_DIR, 0);
		xfer(1, OFS_P1_SEL, 32'hff);
		p1_ext <= 8'h0d;
		p2_ext <= 8'h06;
		repeat (3) @(posedge clk);
		#1 chk("periph in", {timer_clock_input, capture_input_a0, capture_input_a1,
			capture_input_a2, timer_alternate_clock_input, capture_input_b0}, 6'h2f);
		xfer(0, OFS_P1_IN, 0);
		chk("p1 in", rd, 8'h0d);
		$display("routing done");
		xfer(1, OFS_P1_EN, 1);
		for (int e = 0; e < 2; e++) begin
			xfer(1, OFS_P1_EDGE, e);
			xfer(1, OFS_P1_FLAG, 0);
			p1_ext <= 8'h0c;
			repeat (4) @(posedge clk);
			#1 chk("fall", p1_irq, e);
			xfer(1, OFS_P1_FLAG, 0);
			p1_ext <= 8'h0d;
			repeat (4) @(posedge clk);
			#1 chk("rise", p1_irq, !e);
		end
		xfer(1, OFS_P2_EN, 32'hc0);
		xfer(1, OFS_P2_FLAG, 0);
		p2_ext <= 8'hc6;
		repeat (4) @(posedge clk);
		#1 chk("no pad", p2_irq, 0);
		xfer(1, OFS_P2_FLAG, 32'h80);
		@(posedge clk);
		#1 chk("soft irq", p2_irq, 1);
		xfer(1, OFS_P2_EN, 32'h40);
		@(posedge clk);
		#1 chk("masked", p2_irq, 0);
		$display("interrupts done");
		complete_run;
	end
endmodule // dual_port_pin_function_mux_bench
